// ### verilog/bls_defs.svh
// Constants shared by both ends of the serial register link
`ifndef BLS_DEFS_SVH
`define BLS_DEFS_SVH
`define BLS_ADDR7 7'h2C
`define BLS_CLK_HZ 100000000
`define BLS_SCL_HZ 400000
`define BLS_SCL_HALF ((`BLS_CLK_HZ / `BLS_SCL_HZ) / 2)
`define BLS_HALF_W 8
`define BLS_NREG 256
`define BLS_CFG_BASE 8'h70
`define BLS_CFG_NUM 8
`define BLS_NVM_CTL 8'h72
`define BLS_NVM_READ_BIT 0
`define BLS_NVM_PROG_BIT 1
`endif

// ### verilog/bls_pkg.sv
// Types shared by both ends of the serial register link
package bls_pkg;
	typedef enum logic [2:0] {
		SL_IDLE, SL_ADDR, SL_ADDR_ACK, SL_RX, SL_RX_ACK, SL_TX, SL_TX_ACK, SL_IGNORE
	} bls_slave_state_t;
	typedef enum logic [3:0] {
		MS_IDLE, MS_START, MS_BIT_LO, MS_BIT_HI, MS_ACK_LO, MS_ACK_HI,
		MS_NEXT, MS_RSTART, MS_STOP_LO, MS_STOP_HI, MS_DONE
	} bls_master_state_t;
endpackage

// ### verilog/bls_link_if.sv
// Two-wire link between the register slave and the bus master
`timescale 1ns/100ps
interface bls_link_if;
	logic scl_out;
	logic scl_oe;
	logic sda_m_out;
	logic sda_m_oe;
	logic sda_s_out;
	logic sda_s_oe;
	logic scl;
	logic sda;
	// Open-drain wired-AND with pull-ups
	assign scl = !(scl_oe && !scl_out);
	assign sda = !((sda_m_oe && !sda_m_out) || (sda_s_oe && !sda_s_out));
	modport slave (input scl, input sda, output sda_s_out, output sda_s_oe);
	modport master (input scl, input sda, output scl_out, output scl_oe,
		output sda_m_out, output sda_m_oe);
endinterface

// ### verilog/bls_slave.sv
// Register slave end of the two-wire link with configuration memory front end
`timescale 1ns/100ps
`include "bls_defs.svh"
module bls_slave (
	input wire logic CLK,
	input wire logic NRST,
	bls_link_if.slave LINK,
	output logic BUSY,
	output logic [7:0] CFG [`BLS_CFG_NUM],
	output logic [7:0] CTRL0,
	output logic [7:0] CTRL1
);
	typedef struct packed {
		logic [1:0] scl_sync;
		logic [1:0] sda_sync;
		logic scl_d;
		logic sda_d;
		bls_pkg::bls_slave_state_t st;
		logic [2:0] bit_cnt;
		logic [7:0] shreg;
		logic index_phase;
		logic [7:0] index;
		logic sda_low;
		logic busy;
		logic mid_bit;
	} bls_slave_st_t;

	bls_slave_st_t s;
	bls_slave_st_t next_s;
	logic [7:0] regs [`BLS_NREG];
	logic [7:0] nvm [`BLS_CFG_NUM];
	logic wr_en;
	logic [7:0] wr_idx;
	logic [7:0] wr_data;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;

	assign scl_rise = s.scl_sync[1] && !s.scl_d;
	assign scl_fall = !s.scl_sync[1] && s.scl_d;
	assign start_c = s.scl_sync[1] && s.scl_d && s.sda_d && !s.sda_sync[1];
	assign stop_c = s.scl_sync[1] && s.scl_d && !s.sda_d && s.sda_sync[1];

	always_comb begin
		next_s = s;
		wr_en = 1'b0;
		wr_idx = s.index;
		wr_data = s.shreg;
		next_s.scl_sync = {s.scl_sync[0], LINK.scl};
		next_s.sda_sync = {s.sda_sync[0], LINK.sda};
		next_s.scl_d = s.scl_sync[1];
		next_s.sda_d = s.sda_sync[1];
		if (scl_rise) begin
			next_s.mid_bit = 1'b1;
		end
		if (scl_fall) begin
			next_s.mid_bit = 1'b0;
		end
		if (start_c) begin
			// Repeated start keeps the index for the following read
			next_s.st = bls_pkg::SL_ADDR;
			next_s.bit_cnt = 3'h0;
			next_s.sda_low = 1'b0;
			next_s.busy = 1'b1;
			next_s.mid_bit = 1'b0;
		end else if (stop_c) begin
			// A rise at clock high inside a byte aborts the transfer the same way
			next_s.st = bls_pkg::SL_IDLE;
			next_s.sda_low = 1'b0;
			next_s.busy = 1'b0;
			next_s.mid_bit = 1'b0;
		end else begin
			unique case (s.st)
				bls_pkg::SL_IDLE, bls_pkg::SL_IGNORE: begin
				end
				bls_pkg::SL_ADDR, bls_pkg::SL_RX: begin
					if (scl_rise) begin
						next_s.shreg = {s.shreg[6:0], s.sda_sync[1]};
						next_s.bit_cnt = s.bit_cnt + 3'h1;
					end
					// The fall that closes a start condition comes before any bit
					if (scl_fall && s.bit_cnt == 3'h0 && s.mid_bit) begin
						if (s.st == bls_pkg::SL_ADDR) begin
							if (s.shreg[7:1] == `BLS_ADDR7) begin
								next_s.st = bls_pkg::SL_ADDR_ACK;
								next_s.sda_low = 1'b1;
								next_s.index_phase = !s.shreg[0];
							end else begin
								next_s.st = bls_pkg::SL_IGNORE;
							end
						end else begin
							next_s.st = bls_pkg::SL_RX_ACK;
							next_s.sda_low = 1'b1;
							if (s.index_phase) begin
								next_s.index = s.shreg;
								next_s.index_phase = 1'b0;
							end else begin
								wr_en = 1'b1;
								wr_data = s.shreg;
							end
						end
					end
				end
				bls_pkg::SL_ADDR_ACK, bls_pkg::SL_RX_ACK: begin
					if (scl_fall) begin
						next_s.sda_low = 1'b0;
						if (s.st == bls_pkg::SL_ADDR_ACK && !s.index_phase) begin
							// Read: first byte comes from the held index
							next_s.st = bls_pkg::SL_TX;
							next_s.shreg = regs[s.index];
							next_s.sda_low = !regs[s.index][7];
							next_s.bit_cnt = 3'h0;
						end else begin
							next_s.st = bls_pkg::SL_RX;
							next_s.bit_cnt = 3'h0;
						end
					end
				end
				bls_pkg::SL_TX: begin
					if (scl_fall) begin
						next_s.bit_cnt = s.bit_cnt + 3'h1;
						if (s.bit_cnt == 3'h7) begin
							next_s.st = bls_pkg::SL_TX_ACK;
							next_s.sda_low = 1'b0;
						end else begin
							next_s.shreg = {s.shreg[6:0], 1'b0};
							next_s.sda_low = !s.shreg[6];
						end
					end
				end
				bls_pkg::SL_TX_ACK: begin
					if (scl_rise) begin
						if (s.sda_sync[1]) begin
							next_s.st = bls_pkg::SL_IGNORE;
						end else begin
							next_s.index = s.index + 8'h01;
						end
					end
					if (scl_fall) begin
						next_s.st = bls_pkg::SL_TX;
						next_s.bit_cnt = 3'h0;
						next_s.shreg = regs[s.index];
						next_s.sda_low = !regs[s.index][7];
					end
				end
			endcase
		end
		// Advance after the data byte has been stored
		if (wr_en) begin
			next_s.index = s.index + 8'h01;
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			s <= '0;
			s.scl_sync <= 2'h3;
			s.sda_sync <= 2'h3;
			s.scl_d <= 1'b1;
			s.sda_d <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// Register file; the control register triggers copy/burn commands
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			for (int i = 0; i < `BLS_NREG; i++) begin
				regs[i] <= 8'h00;
			end
			for (int i = 0; i < `BLS_CFG_NUM; i++) begin
				nvm[i] <= 8'h00;
			end
		end else if (wr_en) begin
			regs[wr_idx] <= wr_data;
			if (wr_idx == `BLS_NVM_CTL && wr_data[`BLS_NVM_READ_BIT]) begin
				for (int i = 0; i < `BLS_CFG_NUM; i++) begin
					regs[`BLS_CFG_BASE + i] <= nvm[i];
				end
			end
			if (wr_idx == `BLS_NVM_CTL && wr_data[`BLS_NVM_PROG_BIT]) begin
				for (int i = 0; i < `BLS_CFG_NUM; i++) begin
					nvm[i] <= regs[`BLS_CFG_BASE + i];
				end
			end
		end
	end

	// Outputs registered straight from flip-flops
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			BUSY <= 1'b0;
			CTRL0 <= 8'h00;
			CTRL1 <= 8'h00;
			for (int i = 0; i < `BLS_CFG_NUM; i++) begin
				CFG[i] <= 8'h00;
			end
		end else begin
			BUSY <= s.busy;
			CTRL0 <= regs[0];
			CTRL1 <= regs[1];
			for (int i = 0; i < `BLS_CFG_NUM; i++) begin
				CFG[i] <= regs[`BLS_CFG_BASE + i];
			end
		end
	end

	assign LINK.sda_s_out = 1'b0;
	assign LINK.sda_s_oe = s.sda_low;
endmodule // bls_slave

// ### verilog/bls_master.sv
// Bus master end of the two-wire link: a burst of up to 15 register writes or reads per request
`timescale 1ns/100ps
`include "bls_defs.svh"
module bls_master (
	input wire logic CLK,
	input wire logic NRST,
	bls_link_if.master LINK,
	input wire logic REQ,
	input wire logic RD,
	input wire logic [7:0] INDEX,
	input wire logic [7:0] WDATA,
	input wire logic [3:0] COUNT,
	output logic BUSY,
	output logic DONE,
	output logic NACK,
	output logic RVALID,
	output logic [7:0] RDATA
);
	typedef struct packed {
		bls_pkg::bls_master_state_t st;
		logic [`BLS_HALF_W-1:0] tmr;
		logic [2:0] bit_cnt;
		logic [1:0] phase;
		logic [3:0] left;
		logic [7:0] sh;
		logic rd;
		logic raddr;
		logic scl_lo;
		logic sda_lo;
		logic [1:0] sda_sync;
		logic busy;
		logic done;
		logic nack;
		logic rvalid;
		logic [7:0] rdata;
		logic [7:0] wdata;
	} bls_master_st_t;
	localparam logic [`BLS_HALF_W-1:0] HALF = `BLS_HALF_W'(`BLS_SCL_HALF - 1);
	bls_master_st_t m;
	bls_master_st_t next_m;
	logic tick;

	assign tick = (m.tmr == '0);

	always_comb begin
		next_m = m;
		next_m.sda_sync = {m.sda_sync[0], LINK.sda};
		next_m.done = 1'b0;
		next_m.rvalid = 1'b0;
		next_m.tmr = tick ? HALF : m.tmr - 1'b1;
		unique case (m.st)
			bls_pkg::MS_IDLE: begin
				next_m.tmr = HALF;
				if (REQ) begin
					next_m.st = bls_pkg::MS_START;
					next_m.busy = 1'b1;
					next_m.nack = 1'b0;
					next_m.rd = RD;
					next_m.raddr = 1'b0;
					next_m.left = (COUNT == 4'h0) ? 4'h1 : COUNT;
					next_m.wdata = WDATA;
					next_m.sh = {`BLS_ADDR7, 1'b0};
					next_m.phase = 2'h0;
					next_m.sda_lo = 1'b1;
				end
			end
			bls_pkg::MS_START: begin
				if (tick) begin
					next_m.scl_lo = 1'b1;
					next_m.bit_cnt = 3'h0;
					next_m.st = bls_pkg::MS_BIT_LO;
				end
			end
			bls_pkg::MS_BIT_LO: begin
				if (tick) begin
					next_m.scl_lo = 1'b0;
					next_m.st = bls_pkg::MS_BIT_HI;
				end else begin
					// Data changes only with clock low
					next_m.sda_lo = (m.phase == 2'h3) ? 1'b0 : !m.sh[7];
				end
			end
			bls_pkg::MS_BIT_HI: begin
				if (tick) begin
					next_m.scl_lo = 1'b1;
					next_m.sh = {m.sh[6:0], m.sda_sync[1]};
					next_m.bit_cnt = m.bit_cnt + 3'h1;
					next_m.st = (m.bit_cnt == 3'h7) ? bls_pkg::MS_ACK_LO : bls_pkg::MS_BIT_LO;
				end
			end
			bls_pkg::MS_ACK_LO: begin
				if (tick) begin
					next_m.scl_lo = 1'b0;
					next_m.st = bls_pkg::MS_ACK_HI;
				end else begin
					// Drive ack only when reading and more bytes remain
					next_m.sda_lo = (m.phase == 2'h3) && (m.left != 4'h1);
				end
			end
			bls_pkg::MS_ACK_HI: begin
				if (tick) begin
					next_m.scl_lo = 1'b1;
					next_m.st = bls_pkg::MS_NEXT;
					if (m.phase != 2'h3 && m.sda_sync[1]) begin
						next_m.nack = 1'b1;
						next_m.st = bls_pkg::MS_STOP_LO;
					end
					if (m.phase == 2'h3) begin
						next_m.rvalid = 1'b1;
						next_m.rdata = m.sh;
					end
				end
			end
			bls_pkg::MS_NEXT: begin
				next_m.tmr = HALF;
				next_m.bit_cnt = 3'h0;
				next_m.st = bls_pkg::MS_BIT_LO;
				unique case (m.phase)
					2'h0: begin
						if (m.raddr) begin
							// Read address acknowledged: data bytes follow
							next_m.phase = 2'h3;
							next_m.raddr = 1'b0;
							next_m.sh = 8'hFF;
						end else begin
							next_m.phase = 2'h1;
							next_m.sh = INDEX;
						end
					end
					2'h1: begin
						if (m.rd) begin
							next_m.st = bls_pkg::MS_RSTART;
							next_m.sda_lo = 1'b0;
						end else begin
							next_m.phase = 2'h2;
							next_m.sh = m.wdata;
						end
					end
					2'h2: begin
						next_m.st = bls_pkg::MS_STOP_LO;
					end
					2'h3: begin
						if (m.left == 4'h1) begin
							next_m.st = bls_pkg::MS_STOP_LO;
						end else begin
							next_m.left = m.left - 4'h1;
							next_m.sh = 8'hFF;
						end
					end
				endcase
				if (m.phase == 2'h2 && m.left != 4'h1) begin
					next_m.left = m.left - 4'h1;
					next_m.sh = m.wdata + 8'h01;
					next_m.wdata = m.wdata + 8'h01;
					next_m.st = bls_pkg::MS_BIT_LO;
				end
			end
			bls_pkg::MS_RSTART: begin
				// Release data, raise clock, then pull data low with clock high
				if (tick) begin
					if (m.scl_lo) begin
						next_m.scl_lo = 1'b0;
					end else if (!m.sda_lo) begin
						next_m.sda_lo = 1'b1;
					end else begin
						// Read address is sent and its acknowledge checked like any address
						next_m.st = bls_pkg::MS_START;
						next_m.phase = 2'h0;
						next_m.raddr = 1'b1;
						next_m.sh = {`BLS_ADDR7, 1'b1};
					end
				end
			end
			bls_pkg::MS_STOP_LO: begin
				if (tick) begin
					next_m.scl_lo = 1'b0;
					next_m.st = bls_pkg::MS_STOP_HI;
				end else begin
					// Data goes low while the clock is still low
					next_m.sda_lo = 1'b1;
				end
			end
			bls_pkg::MS_STOP_HI: begin
				if (tick) begin
					next_m.sda_lo = 1'b0;
					next_m.st = bls_pkg::MS_DONE;
				end
			end
			bls_pkg::MS_DONE: begin
				// Bus free time before the next request
				if (tick) begin
					next_m.busy = 1'b0;
					next_m.done = 1'b1;
					next_m.st = bls_pkg::MS_IDLE;
				end
			end
			default: begin
				next_m.st = bls_pkg::MS_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			m <= '0;
			m.sda_sync <= 2'h3;
		end else begin
			m <= next_m;
		end
	end

	assign LINK.scl_out = 1'b0;
	assign LINK.scl_oe = m.scl_lo;
	assign LINK.sda_m_out = 1'b0;
	assign LINK.sda_m_oe = m.sda_lo;
	assign BUSY = m.busy;
	assign DONE = m.done;
	assign NACK = m.nack;
	assign RVALID = m.rvalid;
	assign RDATA = m.rdata;
endmodule // bls_master

// ### test/bls_link_monitor.sv
// Protocol checker watching the link between the slave and the master
`timescale 1ns/100ps
`include "bls_defs.svh"
module bls_link_monitor (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_s_out,
	input wire logic sda_s_oe,
	input wire logic BUSY
);
	logic scl_q;
	logic sda_q;
	logic rw;
	logic nacked;
	logic [3:0] bitcnt;
	logic [7:0] bytecnt;
	logic [7:0] sh;
	wire start = scl && scl_q && sda_q && !sda;
	wire stop = scl && scl_q && !sda_q && sda;
	wire rise = scl && !scl_q;
	wire pull = sda_s_oe && !sda_s_out;
	// Tracks the byte position seen on the wire, independent of the slave's own counters
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			rw <= 1'b0;
			nacked <= 1'b0;
			bitcnt <= 4'h0;
			bytecnt <= 8'h00;
			sh <= 8'h00;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			if (start) begin
				bitcnt <= 4'h0;
				bytecnt <= 8'h00;
				nacked <= 1'b0;
			end else if (rise) begin
				bitcnt <= (bitcnt == 4'h8) ? 4'h0 : bitcnt + 4'h1;
				if (bitcnt != 4'h8)
					sh <= {sh[6:0], sda};
				if (bitcnt == 4'h7 && bytecnt == 8'h00)
					rw <= sda;
				if (bitcnt == 4'h8)
					bytecnt <= bytecnt + 8'h01;
				if (bitcnt == 4'h8 && rw && bytecnt != 8'h00 && sda)
					nacked <= 1'b1;
			end
		end
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);
	a_ack_own_addr: assert property (
		rise && bitcnt == 4'h8 && bytecnt == 8'h00 |-> sda == (sh[7:1] != `BLS_ADDR7))
		else $error("Address acknowledge does not match the address sent");
	a_ack_write_byte: assert property (
		rise && bitcnt == 4'h8 && bytecnt != 8'h00 && !rw |-> !sda)
		else $error("Written byte not acknowledged");
	a_release_master_ack: assert property (
		rise && bitcnt == 4'h8 && bytecnt != 8'h00 && rw |-> !pull)
		else $error("Slave holds data line during master acknowledge");
	a_change_clock_low: assert property (
		$changed(pull) |-> !scl)
		else $error("Slave changed data line while clock high");
	a_quiet_after_nack: assert property (
		nacked |-> !pull)
		else $error("Slave drives data line after negative acknowledge");
	a_busy_at_start: assert property (
		start |-> ##[1:8] BUSY)
		else $error("Busy not raised after start");
	a_idle_after_stop: assert property (
		stop |-> ##[1:8] !BUSY)
		else $error("Busy not cleared after stop");
	a_listen_in_rx: assert property (
		rise && bitcnt != 4'h8 && (!rw || bytecnt == 8'h00) |-> !pull)
		else $error("Slave drives data line while receiving");
endmodule // bls_link_monitor

// ### test/tb.sv
// Self-checking bench for both ends of the serial register link
`timescale 1ns/100ps
module tb;
	logic clk;
	logic nrst;
	logic req;
	logic rd;
	logic m_busy;
	logic done;
	logic nack;
	logic rvalid;
	logic s_busy;
	logic [7:0] index;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic [7:0] ctrl0;
	logic [7:0] ctrl1;
	logic [7:0] c2_ctrl0;
	logic [3:0] count;
	logic [7:0] cfg [8];
	logic [7:0] rq [$];
	int mismatches;
	int n_tests;
	bls_link_if l_if();
	// Second link lets the bench break the bus rules that the master never breaks
	bls_link_if b_if();
	bls_slave i_bls_slave (.CLK(clk), .NRST(nrst), .LINK(l_if.slave), .BUSY(s_busy),
		.CFG(cfg), .CTRL0(ctrl0), .CTRL1(ctrl1));
	bls_slave i_bls_slave_2 (.CLK(clk), .NRST(nrst), .LINK(b_if.slave), .BUSY(),
		.CFG(), .CTRL0(c2_ctrl0), .CTRL1());
	bls_master i_bls_master (.CLK(clk), .NRST(nrst), .LINK(l_if.master), .REQ(req),
		.RD(rd), .INDEX(index), .WDATA(wdata), .COUNT(count), .BUSY(m_busy), .DONE(done),
		.NACK(nack), .RVALID(rvalid), .RDATA(rdata));
	bls_link_monitor i_bls_link_monitor (.CLK(clk), .NRST(nrst), .scl(l_if.scl),
		.sda(l_if.sda), .sda_s_out(l_if.sda_s_out), .sda_s_oe(l_if.sda_s_oe), .BUSY(s_busy));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk1(input string what, input logic exp, input logic got);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %b seen %b", what, exp, got);
		end
	endtask
	// REQ stays up until BUSY shows, since the master samples it only when idle
	task automatic txn(input logic r, input logic [7:0] idx, input logic [7:0] d,
		input logic [3:0] n);
		int i;
		rq.delete();
		@(negedge clk);
		rd = r;
		index = idx;
		wdata = d;
		count = n;
		req = 1'b1;
		for (i = 0; i < 40000; i++) begin
			@(negedge clk);
			if (m_busy)
				req = 1'b0;
			if (rvalid)
				rq.push_back(rdata);
			if (done)
				break;
		end
		if (i == 40000) begin
			mismatches++;
			print_verdict();
		end
		chk1("master nack", 1'b0, nack);
	endtask
	task automatic bb_bit(input logic b, output logic s);
		b_if.sda_m_oe = !b;
		#62.5 b_if.scl_oe = 1'b0;
		#31.2 s = b_if.sda;
		#31.3 b_if.scl_oe = 1'b1;
	endtask
	task automatic bb_byte(input logic [7:0] v, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bb_bit(v[i], s);
		bb_bit(1'b1, ack);
	endtask
	task automatic bb_start();
		b_if.sda_m_oe = 1'b1;
		#62.5 b_if.scl_oe = 1'b1;
	endtask
	task automatic bb_stop();
		b_if.sda_m_oe = 1'b1;
		#62.5 b_if.scl_oe = 1'b0;
		#62.5 b_if.sda_m_oe = 1'b0;
		#125;
	endtask
	task automatic t_write_burst();
		txn(1'b0, 8'h00, 8'hA5, 4'h2);
		chk8("ctrl0", 8'hA5, ctrl0);
		chk8("ctrl1", 8'hA6, ctrl1);
		chk1("scl idle", 1'b1, l_if.scl);
		chk1("slave busy", 1'b0, s_busy);
		$display("t_write_burst done");
	endtask
	task automatic t_read_burst();
		txn(1'b1, 8'h00, 8'h00, 4'h2);
		chk8("read count", 8'h02, 8'(rq.size()));
		chk8("read first", 8'hA5, rq[0]);
		chk8("read next", 8'hA6, rq[1]);
		chk1("sda idle", 1'b1, l_if.sda);
		$display("t_read_burst done");
	endtask
	task automatic t_cfg_front();
		txn(1'b0, 8'h73, 8'h11, 4'h5);
		for (int i = 3; i < 8; i++)
			chk8("cfg byte", 8'h11 + 8'(i - 3), cfg[i]);
		txn(1'b1, 8'h76, 8'h00, 4'h2);
		chk8("cfg read a", 8'h14, rq[0]);
		chk8("cfg read b", 8'h15, rq[1]);
		// Burn the front end, change one byte, then copy the stored bytes back
		txn(1'b0, 8'h72, 8'h02, 4'h1);
		txn(1'b0, 8'h73, 8'h40, 4'h1);
		chk8("cfg before copy", 8'h40, cfg[3]);
		txn(1'b0, 8'h72, 8'h01, 4'h1);
		chk8("cfg after copy", 8'h11, cfg[3]);
		$display("t_cfg_front done");
	endtask
	task automatic t_wire_faults();
		logic a;
		bb_start();
		bb_byte(8'h58, a);
		chk1("ack own", 1'b0, a);
		bb_byte(8'h00, a);
		bb_byte(8'h3C, a);
		chk1("ack data", 1'b0, a);
		bb_stop();
		chk8("second ctrl0", 8'h3C, c2_ctrl0);
		bb_start();
		bb_byte(8'h5A, a);
		chk1("ack foreign", 1'b1, a);
		bb_byte(8'h00, a);
		bb_byte(8'h77, a);
		bb_stop();
		chk8("foreign ignored", 8'h3C, c2_ctrl0);
		bb_start();
		bb_byte(8'h58, a);
		bb_byte(8'h00, a);
		// Data line rises in the middle of the high phase of the first data bit
		b_if.sda_m_oe = 1'b1;
		#62.5 b_if.scl_oe = 1'b0;
		#31.2 b_if.sda_m_oe = 1'b0;
		#31.3 b_if.scl_oe = 1'b1;
		for (int i = 0; i < 7; i++)
			bb_bit(1'b1, a);
		bb_bit(1'b1, a);
		chk1("ack aborted", 1'b1, a);
		bb_stop();
		chk8("aborted byte", 8'h3C, c2_ctrl0);
		bb_start();
		bb_byte(8'h58, a);
		chk1("ack after abort", 1'b0, a);
		bb_stop();
		$display("t_wire_faults done");
	endtask
	initial begin
		nrst = 1'b0;
		req = 1'b0;
		rd = 1'b0;
		index = 8'h00;
		wdata = 8'h00;
		count = 4'h0;
		b_if.scl_out = 1'b0;
		b_if.sda_m_out = 1'b0;
		b_if.scl_oe = 1'b0;
		b_if.sda_m_oe = 1'b0;
		mismatches = 0;
		n_tests = 0;
		repeat (5) @(posedge clk);
		@(negedge clk);
		nrst = 1'b1;
		repeat (3) @(negedge clk);
		t_write_burst();
		t_read_burst();
		t_cfg_front();
		t_wire_faults();
		print_verdict();
	end
endmodule // tb
